// file: design/sdd_idle_timer.sv
// Idle detector: flags idle after a quiet period with no restart
`timescale 1ns/1ps
`include "sdd_map.svh"
module sdd_idle_timer #(
  parameter int CYCLES = `SDD_IDLE_CYCLES
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic restart,
  output logic      idle
);
  logic [`SDD_IDLE_CNT_W-1:0] cnt;
  logic [`SDD_IDLE_CNT_W-1:0] next_cnt;
  logic                       next_idle;

  always_comb begin
    next_cnt  = cnt;
    next_idle = idle;
    if (restart) begin
      next_cnt  = '0;
      next_idle = 1'b0;
    end else if (cnt >= `SDD_IDLE_CNT_W'(CYCLES - 1)) begin
      next_idle = 1'b1;
    end else begin
      next_cnt = cnt + `SDD_IDLE_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt  <= '0;
      idle <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      idle <= next_idle;
    end
  end
endmodule

// file: design/sdd_map.svh
// Register map, field positions and timing constants of the step/direction input block
`ifndef SDD_MAP_SVH
`define SDD_MAP_SVH

`define SDD_MCLK_HZ        10000000
`define SDD_IDLE_MS        100
`define SDD_IDLE_CYCLES    (`SDD_IDLE_MS * (`SDD_MCLK_HZ / 1000))
`define SDD_IDLE_CNT_W     24

`define SDD_ADDR_W         8
`define SDD_OFS_CTRL       8'h00
`define SDD_OFS_STATUS     8'h04
`define SDD_OFS_POSITION   8'h08
`define SDD_OFS_RES        8'h0C
`define SDD_OFS_IRQ_STAT   8'h10
`define SDD_OFS_IRQ_MASK   8'h14

`define SDD_CTRL_RESET     32'h00000001
`define SDD_CTRL_SW_EN     0
`define SDD_CTRL_FLT_CLR   1

`define SDD_ST_ENABLED     0
`define SDD_ST_FAULT       1
`define SDD_ST_IDLE        2
`define SDD_ST_DIR         3

`define SDD_IRQ_W          3
`define SDD_IRQ_FAULT      0
`define SDD_IRQ_IDLE       1
`define SDD_IRQ_ENCHG      2

`define SDD_PCT_W          7
`define SDD_PCT_RUN        7'h64
`define SDD_PCT_IDLE_HI    7'h5A
`define SDD_PCT_IDLE_LO    7'h32
`define SDD_PCT_OFF        7'h00

`endif

// file: design/sdd_pkg.sv
// Types shared by the step/direction input block
package sdd_pkg;
  typedef enum logic [1:0] {
    SDD_DISABLED,
    SDD_RUN,
    SDD_IDLE,
    SDD_FAULT
  } sdd_state_type;
endpackage

// file: design/sdd_sync.sv
// Two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module sdd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// file: design/sdd_top.sv
// Step/direction command input, protection and fault signalling of a stepper drive
`timescale 1ns/1ps
`include "sdd_map.svh"
module sdd_top #(
  parameter int IDLE_CYCLES = `SDD_IDLE_CYCLES
) (
  input  wire logic                    MCLK,
  input  wire logic                    NRST,
  input  wire logic                    STEP_PULSE_IN,
  input  wire logic                    DIR_IN,
  input  wire logic                    DRIVE_DISABLE_IN,
  input  wire logic                    OVER_VOLT_IN,
  input  wire logic                    OVER_CURR_IN,
  input  wire logic [3:0]              RES_SW,
  input  wire logic                    IDLE_SEL_SW,
  input  wire logic [`SDD_ADDR_W-1:0]  REG_ADDR,
  input  wire logic [31:0]             REG_WDATA,
  input  wire logic                    REG_WR,
  input  wire logic                    REG_RD,
  output logic      [31:0]             REG_RDATA,
  output logic                         IRQ,
  output logic                         FAULT_OUT,
  output logic                         FAULT_OUT_OE,
  output logic      [15:0]             MICROSTEP_POS,
  output logic      [`SDD_PCT_W-1:0]   CURRENT_PCT
);
  // Steps per revolution for each switch code
  function automatic logic [15:0] res_steps(input logic [3:0] sel);
    case (sel)
      4'h0:    res_steps = 16'h00C8;
      4'h1:    res_steps = 16'h0190;
      4'h2:    res_steps = 16'h0320;
      4'h3:    res_steps = 16'h0640;
      4'h4:    res_steps = 16'h0C80;
      4'h5:    res_steps = 16'h1900;
      4'h6:    res_steps = 16'h3200;
      4'h7:    res_steps = 16'h6400;
      4'h8:    res_steps = 16'hC800;
      4'h9:    res_steps = 16'h03E8;
      4'hA:    res_steps = 16'h07D0;
      4'hB:    res_steps = 16'h0FA0;
      4'hC:    res_steps = 16'h1388;
      4'hD:    res_steps = 16'h1F40;
      4'hE:    res_steps = 16'h2710;
      default: res_steps = 16'h4E20;
    endcase
  endfunction

  logic [9:0]  sync_q;
  logic        step_s;
  logic        dir_s;
  logic        dis_s;
  logic        ov_s;
  logic        oc_s;
  logic [3:0]  res_s;
  logic        idle_sel_s;
  logic        step_d;
  logic        step_edge;
  logic        idle_flag;
  logic        enabled;
  logic        step_taken;
  logic [15:0] rev;

  sdd_sync #(
    .W (10)
  ) u_sync (
    .clk      (MCLK),
    .nrst     (NRST),
    .async_in ({IDLE_SEL_SW, RES_SW, OVER_CURR_IN, OVER_VOLT_IN,
                DRIVE_DISABLE_IN, DIR_IN, STEP_PULSE_IN}),
    .sync_out (sync_q)
  );

  assign step_s     = sync_q[0];
  assign dir_s      = sync_q[1];
  assign dis_s      = sync_q[2];
  assign ov_s       = sync_q[3];
  assign oc_s       = sync_q[4];
  assign res_s      = sync_q[8:5];
  assign idle_sel_s = sync_q[9];
  assign step_edge  = step_s & ~step_d;
  assign rev        = res_steps(res_s);

  // Control state
  sdd_pkg::sdd_state_type state;
  sdd_pkg::sdd_state_type next_state;
  logic [31:0]            ctrl;
  logic [31:0]            next_ctrl;
  logic                   fault;
  logic                   next_fault;
  logic [15:0]            pos;
  logic [15:0]            next_pos;
  logic                   fault_clr;

  assign enabled    = (state == sdd_pkg::SDD_RUN) || (state == sdd_pkg::SDD_IDLE);
  assign step_taken = step_edge && enabled;
  assign fault_clr  = REG_WR && (REG_ADDR == `SDD_OFS_CTRL) && REG_WDATA[`SDD_CTRL_FLT_CLR];

  sdd_idle_timer #(
    .CYCLES (IDLE_CYCLES)
  ) u_idle (
    .clk     (MCLK),
    .nrst    (NRST),
    .restart (step_taken || !enabled),
    .idle    (idle_flag)
  );

  always_comb begin
    next_ctrl = ctrl;
    if (REG_WR && (REG_ADDR == `SDD_OFS_CTRL)) begin
      next_ctrl = 32'h0;
      next_ctrl[`SDD_CTRL_SW_EN] = REG_WDATA[`SDD_CTRL_SW_EN];
    end
    // Protection latches; a clear only takes once both conditions are gone
    next_fault = ov_s || oc_s || (fault && !fault_clr);
    case (state)
      sdd_pkg::SDD_FAULT: begin
        next_state = next_fault ? sdd_pkg::SDD_FAULT : sdd_pkg::SDD_DISABLED;
      end
      sdd_pkg::SDD_DISABLED, sdd_pkg::SDD_RUN, sdd_pkg::SDD_IDLE: begin
        if (next_fault) begin
          next_state = sdd_pkg::SDD_FAULT;
        end else if (dis_s || !ctrl[`SDD_CTRL_SW_EN]) begin
          next_state = sdd_pkg::SDD_DISABLED;
        end else if (idle_flag && !step_taken) begin
          next_state = sdd_pkg::SDD_IDLE;
        end else begin
          next_state = sdd_pkg::SDD_RUN;
        end
      end
      default: next_state = sdd_pkg::SDD_DISABLED;
    endcase
    next_pos = pos;
    if (pos >= rev) begin
      // Coarser resolution picked in any state: restart the count
      next_pos = 16'h0000;
    end else if (step_taken && dir_s) begin
      next_pos = (pos == rev - 16'h0001) ? 16'h0000 : pos + 16'h0001;
    end else if (step_taken) begin
      next_pos = (pos == 16'h0000) ? rev - 16'h0001 : pos - 16'h0001;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      state  <= sdd_pkg::SDD_DISABLED;
      ctrl   <= `SDD_CTRL_RESET;
      fault  <= 1'b0;
      pos    <= 16'h0000;
      step_d <= 1'b0;
    end else begin
      state  <= next_state;
      ctrl   <= next_ctrl;
      fault  <= next_fault;
      pos    <= next_pos;
      step_d <= step_s;
    end
  end

  // Pin-facing outputs
  logic [`SDD_PCT_W-1:0] next_pct;
  logic                  next_fault_oe;

  always_comb begin
    // Open drain sink released in protection so the line reads high impedance
    next_fault_oe = !next_fault;
    case (next_state)
      sdd_pkg::SDD_RUN: next_pct = `SDD_PCT_RUN;
      sdd_pkg::SDD_IDLE: begin
        next_pct = idle_sel_s ? `SDD_PCT_IDLE_HI : `SDD_PCT_IDLE_LO;
      end
      default: next_pct = `SDD_PCT_OFF;
    endcase
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      FAULT_OUT     <= 1'b0;
      FAULT_OUT_OE  <= 1'b1;
      CURRENT_PCT   <= `SDD_PCT_OFF;
      MICROSTEP_POS <= 16'h0000;
    end else begin
      FAULT_OUT     <= 1'b0;
      FAULT_OUT_OE  <= next_fault_oe;
      CURRENT_PCT   <= next_pct;
      MICROSTEP_POS <= next_pos;
    end
  end

  // Interrupts and register reads
  logic [`SDD_IRQ_W-1:0] irq_stat;
  logic [`SDD_IRQ_W-1:0] next_irq_stat;
  logic [`SDD_IRQ_W-1:0] irq_mask;
  logic [`SDD_IRQ_W-1:0] next_irq_mask;
  logic [`SDD_IRQ_W-1:0] irq_evt;
  logic [31:0]           next_rdata;
  logic                  next_irq;

  always_comb begin
    irq_evt = '0;
    irq_evt[`SDD_IRQ_FAULT] = next_fault && !fault;
    irq_evt[`SDD_IRQ_IDLE]  = (next_state == sdd_pkg::SDD_IDLE) && (state == sdd_pkg::SDD_RUN);
    irq_evt[`SDD_IRQ_ENCHG] = (next_state == sdd_pkg::SDD_DISABLED)
                              != (state == sdd_pkg::SDD_DISABLED);
    next_irq_stat = irq_stat;
    if (REG_RD && (REG_ADDR == `SDD_OFS_IRQ_STAT)) begin
      next_irq_stat = '0;
    end
    // Event in the clearing cycle survives
    next_irq_stat = next_irq_stat | irq_evt;
    next_irq_mask = irq_mask;
    if (REG_WR && (REG_ADDR == `SDD_OFS_IRQ_MASK)) begin
      next_irq_mask = REG_WDATA[`SDD_IRQ_W-1:0];
    end
    next_irq   = |(next_irq_stat & next_irq_mask);
    next_rdata = 32'h0;
    if (REG_RD) begin
      case (REG_ADDR)
        `SDD_OFS_CTRL: next_rdata = ctrl;
        `SDD_OFS_STATUS: begin
          next_rdata[`SDD_ST_ENABLED] = enabled;
          next_rdata[`SDD_ST_FAULT]   = fault;
          next_rdata[`SDD_ST_IDLE]    = state == sdd_pkg::SDD_IDLE;
          next_rdata[`SDD_ST_DIR]     = dir_s;
        end
        `SDD_OFS_POSITION: next_rdata = {16'h0000, pos};
        `SDD_OFS_RES:      next_rdata = {16'h0000, rev};
        `SDD_OFS_IRQ_STAT: next_rdata = {29'h0, irq_stat};
        `SDD_OFS_IRQ_MASK: next_rdata = {29'h0, irq_mask};
        default:           next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      irq_stat  <= '0;
      irq_mask  <= '0;
      IRQ       <= 1'b0;
      REG_RDATA <= 32'h0;
    end else begin
      irq_stat  <= next_irq_stat;
      irq_mask  <= next_irq_mask;
      IRQ       <= next_irq;
      REG_RDATA <= next_rdata;
    end
  end

  // Checks
  property p_disable_enters;
    @(posedge MCLK) disable iff (!NRST)
      (dis_s && !ov_s && !oc_s && !fault)
      |=> (state == sdd_pkg::SDD_DISABLED);
  endproperty
  a_disable_enters: assert property (p_disable_enters)
    else $error("disable input did not disable the drive");

  property p_disabled_holds_pos;
    @(posedge MCLK) disable iff (!NRST)
      (state == sdd_pkg::SDD_DISABLED && pos < rev) ##1 $stable(res_s)
      |-> $stable(pos);
  endproperty
  a_disabled_holds_pos: assert property (p_disabled_holds_pos)
    else $error("position moved while disabled");

  property p_fault_released;
    @(posedge MCLK) disable iff (!NRST)
      (!fault && !ov_s && !oc_s) |=> (FAULT_OUT_OE && !FAULT_OUT);
  endproperty
  a_fault_released: assert property (p_fault_released)
    else $error("fault output not low impedance in normal operation");

  property p_protect_entry;
    @(posedge MCLK) disable iff (!NRST)
      (ov_s || oc_s)
      |=> (!FAULT_OUT_OE && state == sdd_pkg::SDD_FAULT && CURRENT_PCT == `SDD_PCT_OFF);
  endproperty
  a_protect_entry: assert property (p_protect_entry)
    else $error("protection not entered on over-voltage or over-current");

  property p_res_wrap;
    @(posedge MCLK) disable iff (!NRST)
      (pos >= rev) |=> (pos == 16'h0000);
  endproperty
  a_res_wrap: assert property (p_res_wrap)
    else $error("position beyond the selected resolution");

  property p_idle_current;
    @(posedge MCLK) disable iff (!NRST)
      // Output register lags the switch by one cycle
      (state == sdd_pkg::SDD_IDLE)
      |-> (CURRENT_PCT == ($past(idle_sel_s) ? `SDD_PCT_IDLE_HI : `SDD_PCT_IDLE_LO));
  endproperty
  a_idle_current: assert property (p_idle_current)
    else $error("idle current level wrong");

  property p_step_up;
    @(posedge MCLK) disable iff (!NRST)
      (step_edge && enabled && dir_s && pos < rev - 16'h0001)
      |=> (pos == $past(pos) + 16'h0001) ##0 (MICROSTEP_POS == pos);
  endproperty
  a_step_up: assert property (p_step_up)
    else $error("forward step did not increment position");

  property p_step_down;
    @(posedge MCLK) disable iff (!NRST)
      (step_edge && enabled && !dir_s && pos != 16'h0000 && pos < rev)
      |=> (pos == $past(pos) - 16'h0001);
  endproperty
  a_step_down: assert property (p_step_down)
    else $error("reverse step did not decrement position");

  c_step:  cover property (@(posedge MCLK) disable iff (!NRST) step_taken ##[1:60] step_taken);
  c_fault: cover property (@(posedge MCLK) disable iff (!NRST) $rose(fault) ##[1:50] !fault);
  c_idle:  cover property (@(posedge MCLK) disable iff (!NRST) state == sdd_pkg::SDD_IDLE);
endmodule

// file: testbench/sdd_ctrl_model.sv
// Behavioural motion controller driving the step and direction lines
`timescale 1ns/1ps
module sdd_ctrl_model #(
  parameter int PW    = 25,
  parameter int SETUP = 50
) (
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic       dir_req,
  input  wire logic [7:0] n_steps,
  input  wire logic [7:0] gap,
  output logic            step_pulse_in,
  output logic            dir_out,
  output logic            busy
);
  initial begin
    step_pulse_in = 1'b0;
    dir_out       = 1'b0;
    busy          = 1'b0;
  end
  // Step line rests low between bursts, like an idle controller
  always begin
    @(posedge clk);
    if (start) begin
      busy    <= 1'b1;
      dir_out <= dir_req;
      repeat (SETUP) @(posedge clk);
      for (int i = 0; i < n_steps; i++) begin
        step_pulse_in <= 1'b1;
        repeat (PW) @(posedge clk);
        step_pulse_in <= 1'b0;
        repeat (PW + gap) @(posedge clk);
      end
      busy <= 1'b0;
    end
  end
endmodule

// file: testbench/step_direction_drive_input_tb_top.sv
// Self-checking bench for the step/direction input block
`timescale 1ns/1ps
`include "sdd_map.svh"
module step_direction_drive_input_tb_top;
  localparam int IDLE = 200;
  localparam int RES_TAB [16] = '{200, 400, 800, 1600, 3200, 6400, 12800, 25600,
                                  51200, 1000, 2000, 4000, 5000, 8000, 10000, 20000};
  logic        MCLK             = 1'b0;
  logic        NRST             = 1'b0;
  logic        DRIVE_DISABLE_IN = 1'b0;
  logic        OVER_VOLT_IN     = 1'b0;
  logic        OVER_CURR_IN     = 1'b0;
  logic [3:0]  RES_SW           = 4'h0;
  logic        IDLE_SEL_SW      = 1'b0;
  logic [7:0]  REG_ADDR         = 8'h00;
  logic [31:0] REG_WDATA        = 32'h0;
  logic        REG_WR           = 1'b0;
  logic        REG_RD           = 1'b0;
  logic        start            = 1'b0;
  logic        dir_req          = 1'b0;
  logic [7:0]  n_steps          = 8'h00;
  logic [7:0]  gap              = 8'h00;
  logic [31:0] REG_RDATA;
  logic        IRQ;
  logic        FAULT_OUT;
  logic        FAULT_OUT_OE;
  logic [15:0] MICROSTEP_POS;
  logic [6:0]  CURRENT_PCT;
  logic        step;
  logic        dir;
  logic        busy;
  logic [31:0] rd;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cyc        = 0;
  int          exp_pos    = 0;

  always #50 MCLK = ~MCLK;

  sdd_ctrl_model i_ctrl (
    .clk          (MCLK),
    .start        (start),
    .dir_req      (dir_req),
    .n_steps      (n_steps),
    .gap          (gap),
    .step_pulse_in(step),
    .dir_out      (dir),
    .busy         (busy)
  );

  sdd_top #(.IDLE_CYCLES(IDLE)) i_dut (
    .MCLK            (MCLK),
    .NRST            (NRST),
    .STEP_PULSE_IN   (step),
    .DIR_IN          (dir),
    .DRIVE_DISABLE_IN(DRIVE_DISABLE_IN),
    .OVER_VOLT_IN    (OVER_VOLT_IN),
    .OVER_CURR_IN    (OVER_CURR_IN),
    .RES_SW          (RES_SW),
    .IDLE_SEL_SW     (IDLE_SEL_SW),
    .REG_ADDR        (REG_ADDR),
    .REG_WDATA       (REG_WDATA),
    .REG_WR          (REG_WR),
    .REG_RD          (REG_RD),
    .REG_RDATA       (REG_RDATA),
    .IRQ             (IRQ),
    .FAULT_OUT       (FAULT_OUT),
    .FAULT_OUT_OE    (FAULT_OUT_OE),
    .MICROSTEP_POS   (MICROSTEP_POS),
    .CURRENT_PCT     (CURRENT_PCT)
  );

  function automatic int next_pos(int p, logic d, int n);
    return d ? (p + n) % 200 : (p + 200 - n) % 200;
  endfunction

  function automatic logic [31:0] res_steps(logic [3:0] c);
    return 32'(RES_TAB[c]);
  endfunction

  task automatic test_done();
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    REG_WR    <= 1'b1;
    REG_ADDR  <= a;
    REG_WDATA <= d;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge MCLK);
    REG_RD   <= 1'b1;
    REG_ADDR <= a;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask

  // Burst through the controller model; position only moves when enabled
  task automatic burst(input logic d, input int n, input int g, input bit en);
    @(posedge MCLK);
    start   <= 1'b1;
    dir_req <= d;
    n_steps <= n[7:0];
    gap     <= g[7:0];
    @(posedge MCLK);
    start <= 1'b0;
    @(posedge MCLK);
    for (int k = 0; busy && k < 20000; k++) @(posedge MCLK);
    #1;
    if (en) exp_pos = next_pos(exp_pos, d, n);
  endtask

  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 50000) begin
      fail_count++;
      test_done();
    end
  end

  initial begin
    void'($urandom(78631));
    repeat (20) @(posedge MCLK);
    chk(FAULT_OUT_OE, 1);
    chk(CURRENT_PCT, 0);
    NRST <= 1'b1;
    wait_cyc(6);
    chk(CURRENT_PCT, `SDD_PCT_RUN);
    chk(FAULT_OUT, 0);
    reg_rd(8'h20, rd);
    chk(rd, 0);
    for (int c = 0; c < 16; c++) begin
      @(posedge MCLK);
      RES_SW <= c[3:0];
      wait_cyc(4);
      reg_rd(`SDD_OFS_RES, rd);
      chk(rd, res_steps(c[3:0]));
    end
    @(posedge MCLK);
    RES_SW <= 4'h0;
    wait_cyc(4);
    // Down across zero first, then random bursts
    burst(1'b0, 3, 0, 1'b1);
    chk(MICROSTEP_POS, exp_pos);
    for (int i = 0; i < 5; i++) begin
      burst(1'($urandom_range(0, 1)), $urandom_range(1, 6), $urandom_range(0, 30), 1'b1);
      chk(MICROSTEP_POS, exp_pos);
      reg_rd(`SDD_OFS_POSITION, rd);
      chk(rd, exp_pos);
    end
    // Count past 200 at a finer setting, then fall back: position restarts at zero
    @(posedge MCLK);
    RES_SW <= 4'h1;
    wait_cyc(4);
    burst(1'b1, 200, 0, 1'b0);
    chk(MICROSTEP_POS, exp_pos + 200);
    @(posedge MCLK);
    RES_SW <= 4'h0;
    wait_cyc(5);
    exp_pos = 0;
    chk(MICROSTEP_POS, exp_pos);
    reg_wr(`SDD_OFS_IRQ_MASK, 32'h2);
    for (int s = 0; s < 2; s++) begin
      @(posedge MCLK);
      IDLE_SEL_SW <= s[0];
      burst(1'b1, 1, 0, 1'b1);
      reg_rd(`SDD_OFS_IRQ_STAT, rd);
      chk(CURRENT_PCT, `SDD_PCT_RUN);
      wait_cyc(IDLE + 10);
      chk(CURRENT_PCT, s ? `SDD_PCT_IDLE_HI : `SDD_PCT_IDLE_LO);
      chk(IRQ, 1);
      reg_rd(`SDD_OFS_IRQ_STAT, rd);
      chk(rd[1], 1);
    end
    // Enable hold is far shorter than a real controller's; drive does not enforce it
    reg_wr(`SDD_OFS_IRQ_MASK, 32'h4);
    @(posedge MCLK);
    DRIVE_DISABLE_IN <= 1'b1;
    wait_cyc(50);
    chk(CURRENT_PCT, 0);
    chk(IRQ, 1);
    reg_rd(`SDD_OFS_STATUS, rd);
    chk(rd[0], 0);
    burst(1'b0, 4, 0, 1'b0);
    chk(MICROSTEP_POS, exp_pos);
    @(posedge MCLK);
    DRIVE_DISABLE_IN <= 1'b0;
    wait_cyc(10);
    chk(CURRENT_PCT, `SDD_PCT_RUN);
    for (int src = 0; src < 2; src++) begin
      reg_wr(`SDD_OFS_IRQ_MASK, 32'(src));
      reg_rd(`SDD_OFS_IRQ_STAT, rd);
      @(posedge MCLK);
      OVER_VOLT_IN <= (src == 0);
      OVER_CURR_IN <= (src == 1);
      wait_cyc(3);
      chk(FAULT_OUT_OE, 0);
      chk(CURRENT_PCT, 0);
      chk(IRQ, src);
      // Clear refused while the condition persists
      reg_wr(`SDD_OFS_CTRL, 32'h3);
      wait_cyc(4);
      chk(FAULT_OUT_OE, 0);
      reg_rd(`SDD_OFS_IRQ_STAT, rd);
      chk(rd[0], 1);
      wait_cyc(1);
      chk(IRQ, 0);
      @(posedge MCLK);
      OVER_VOLT_IN <= 1'b0;
      OVER_CURR_IN <= 1'b0;
      // Let the condition clear through the synchroniser before the clear write
      wait_cyc(3);
      reg_wr(`SDD_OFS_CTRL, 32'h3);
      wait_cyc(6);
      chk(FAULT_OUT_OE, 1);
      chk(FAULT_OUT, 0);
    end
    test_done();
  end
endmodule
